// [src/rsc_map.svh]
// register offsets, field positions, reset values and timing figures
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
`define RSC_CLK_MHZ            25
`define RSC_POR_TIME_US        500
`define RSC_XTAL_FIRST_TIME_US 2500
`define RSC_CAL_TIME_US        6500
`define RSC_TUNE_TIME_US       300
`define RSC_RX_TIME_US         20
`define RSC_XTAL_UNIT_US       10
`define RSC_TMR_W              18
`define RSC_NUM_LATCHED        8
`define RSC_NUM_LIVE           6
`define RSC_NUM_SRC            14
`define RSC_WAKE_IRQ_BIT       3'h6
`define RSC_OFS_OPERATION_CONTROL_REG        8'h00
`define RSC_OFS_RESTART        8'h01
`define RSC_OFS_STATUS         8'h02
`define RSC_OFS_PIN_SEL        8'h03
`define RSC_OFS_IRQ_A_SEL      8'h04
`define RSC_OFS_IRQ_B_SEL      8'h05
`define RSC_OFS_IRQ_EN         8'h06
`define RSC_OFS_IRQ_CLR        8'h07
`define RSC_OFS_IRQ_LATCH      8'h08
`define RSC_OFS_IRQ_LIVE       8'h09
`define RSC_OFS_XTAL_STAB      8'h0A
`define RSC_OFS_WAKE_CTL       8'h0B
`define RSC_OFS_WAKE_PERIOD    8'h0C
`define RSC_CMD_SLEEP          5'h01
`define RSC_CMD_STBY           5'h02
`define RSC_CMD_TUNE           5'h04
`define RSC_CMD_RX             5'h08
`define RSC_CMD_EEPROM         5'h10
`define RSC_SOFT_RESET_KEY     8'hFF
`define RSC_RST_XTAL_STAB      8'h32
`define RSC_RST_WAKE_PERIOD    8'h0A
`define RSC_RST_PIN_SEL        8'h00
`define RSC_RST_IRQ_A_SEL      4'h0
`define RSC_RST_IRQ_B_SEL      4'h0
`define RSC_CODE_PUP           3'h0
`define RSC_CODE_SLEEP         3'h1
`define RSC_CODE_STBY          3'h2
`define RSC_CODE_TUNE          3'h3
`define RSC_CODE_RX            3'h4
`define RSC_CODE_EEPROM        3'h5
`endif

// [src/rsc_pkg.sv]
// types shared by the state controller and its interrupt unit
`include "rsc_map.svh"
package rsc_pkg;
    typedef logic [`RSC_TMR_W-1:0] rsc_tmr_t;
    typedef enum {
        ST_POR, ST_XTAL, ST_CAL, ST_SLEEP, ST_TO_STBY, ST_STBY,
        ST_TO_TUNE, ST_TUNE, ST_TO_RX, ST_RX, ST_EEPROM
    } rsc_state_t;
    typedef struct packed {
        rsc_state_t  state;
        rsc_state_t  target;
        rsc_tmr_t    tmr;
        logic [7:0]  pin_sel;
        logic [3:0]  irq_a_sel;
        logic [3:0]  irq_b_sel;
        logic [7:0]  irq_en;
        logic [7:0]  irq_clr;
        logic [7:0]  xtal_stab;
        logic        wake_en;
        logic [7:0]  wake_period;
        logic [7:0]  wake_cnt;
        logic [2:0]  tick_sync;
        logic        wake_evt;
        logic [7:0]  rd_data;
        logic        reset_out_n;
        logic [5:0]  power;
        logic        ref_clk;
        logic [3:0]  pins;
    } rsc_ctl_t;
    typedef struct packed {
        logic [`RSC_NUM_LATCHED-1:0] latched;
        logic [`RSC_NUM_LIVE-1:0]    live;
        logic                        irq_a;
        logic                        irq_b;
    } rsc_irq_t;
endpackage : rsc_pkg

// [src/rsc_irq_if.sv]
// carrier between the state controller and the interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"
interface rsc_irq_if;
    logic [`RSC_NUM_LATCHED-1:0] evt;
    logic [`RSC_NUM_LATCHED-1:0] enable;
    logic [`RSC_NUM_LATCHED-1:0] clear;
    logic [`RSC_NUM_LIVE-1:0]    live;
    logic [3:0]                  sel_a;
    logic [3:0]                  sel_b;
    logic [`RSC_NUM_LATCHED-1:0] latched;
    logic [`RSC_NUM_LIVE-1:0]    live_q;
    logic                        irq_a;
    logic                        irq_b;
    modport ctl  (output evt, enable, clear, live, sel_a, sel_b,
                  input  latched, live_q, irq_a, irq_b);
    modport unit (input  evt, enable, clear, live, sel_a, sel_b,
                  output latched, live_q, irq_a, irq_b);
endinterface : rsc_irq_if
`default_nettype wire

// [src/rsc_irq_unit.sv]
// interrupt source latches and the two source selectors
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"
module rsc_irq_unit
    import rsc_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    rsc_irq_if.unit   irq
);
    rsc_irq_t cur;
    rsc_irq_t nxt;

    // codes 0..7 pick latched sources, 8..13 live ones, the rest read low
    function automatic logic irq_pick(input logic [3:0] sel,
                                      input logic [`RSC_NUM_LATCHED-1:0] lat,
                                      input logic [`RSC_NUM_LIVE-1:0] live);
        logic [`RSC_NUM_SRC-1:0] all;
        all = {live, lat};
        if (sel < 4'hE)
            return all[sel];
        return 1'b0;
    endfunction : irq_pick

    always_comb
    begin
        nxt = cur;
        // a set in the clearing cycle survives the clear
        nxt.latched = (cur.latched & ~irq.clear) | (irq.evt & irq.enable); // see R19 see R22
        nxt.live    = irq.live; // see R20
        nxt.irq_a   = irq_pick(irq.sel_a, cur.latched, cur.live); // see R21
        nxt.irq_b   = irq_pick(irq.sel_b, cur.latched, cur.live); // see R21
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            cur <= '0;
        else
            cur <= nxt;
    end

    assign irq.latched = cur.latched;
    assign irq.live_q  = cur.live;
    assign irq.irq_a   = cur.irq_a;
    assign irq.irq_b   = cur.irq_b;
endmodule : rsc_irq_unit
`default_nettype wire

// [src/rsc_state_ctl.sv]
// operating-state sequencer, register port and output-pin routing
// What this block does
// R1: hold power-on reset about 0.5 ms, then allow 2.5 ms crystal start-up.
// R2: run 6.5 ms calibration once per power cycle, again after soft reset.
// R3: enter dormant state automatically when calibration completes.
// R4: decode a written 5-bit state command into a state transition.
// R5: drive block enables that match each operating state.
// R6: host waits out cumulative step times when jumping several states.
// R7: non-volatile access command is accepted only from the dormant state.
// R8: soft reset returns to power-up, recalibrates, then falls to dormant.
// R9: dormant keeps port alive, blocks queue access, stops the crystal.
// R10: wake timer expiry in dormant moves to standby by itself.
// R11: dormant to standby takes the configured crystal settling time.
// R12: queue contents are held unchanged in standby and synthesizer-lock.
// R13: standby to synthesizer-lock takes about 300 us.
// R14: synthesizer-lock to receive takes about 20 us.
// R15: first pin selects reset out, irq A, irq B or demodulated data.
// R16: second pin selects irq A, irq B or bit clock.
// R17: third pin selects reference clock, irq A, irq B or demodulated data.
// R18: fourth pin selects demodulated data, irq A, irq B or bit clock.
// R19: eight event sources stay latched until software clears them.
// R20: six queue and level sources follow live conditions.
// R21: interrupts active high; irq B has its own 4-bit source select.
// R22: latched sources need enable; writing 1 to clear self-returns to 0.
// R23: commands written mid-transition take effect once it finishes.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"
module rsc_state_ctl
    import rsc_pkg::*;
#(
    parameter int unsigned POR_CYC  = `RSC_POR_TIME_US * `RSC_CLK_MHZ,
    parameter int unsigned XTAL_CYC = `RSC_XTAL_FIRST_TIME_US * `RSC_CLK_MHZ,
    parameter int unsigned CAL_CYC  = `RSC_CAL_TIME_US * `RSC_CLK_MHZ,
    parameter int unsigned TUNE_CYC = `RSC_TUNE_TIME_US * `RSC_CLK_MHZ
)
(
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output var  logic [7:0]                  reg_rdata,
    input  wire logic [`RSC_NUM_LATCHED-1:0] src_events,
    input  wire logic [`RSC_NUM_LIVE-1:0]    queue_status,
    input  wire logic                        demod_data,
    input  wire logic                        bit_clock_in,
    input  wire logic                        slow_oscillator,
    output var  logic                        out_pin_a,
    output var  logic                        out_pin_b,
    output var  logic                        out_pin_c,
    output var  logic                        out_pin_d,
    output var  logic                        spi_on,
    output var  logic                        xtal_on,
    output var  logic                        queue_on,
    output var  logic                        synth_on,
    output var  logic                        frontend_on,
    output var  logic                        queue_write_en
);
    localparam int unsigned RX_CYC        = `RSC_RX_TIME_US * `RSC_CLK_MHZ;
    localparam int unsigned XTAL_UNIT_CYC = `RSC_XTAL_UNIT_US * `RSC_CLK_MHZ;

    rsc_ctl_t  cur;
    rsc_ctl_t  nxt;
    rsc_irq_if irq_bus ();

    rsc_irq_unit u_irq (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .irq     (irq_bus.unit)
    );

    // a figure of n cycles loads n-1, never below one cycle
    function automatic rsc_tmr_t cyc_load(input int unsigned n);
        if (n == 0)
            return '0;
        return rsc_tmr_t'(n - 1);
    endfunction : cyc_load

    // four-way pin selector, used for every output pin
    function automatic logic pin_pick(input logic [1:0] sel,
                                      input logic s0,
                                      input logic s1,
                                      input logic s2,
                                      input logic s3);
        unique case (sel)
            2'h0: return s0;
            2'h1: return s1;
            2'h2: return s2;
            2'h3: return s3;
        endcase
    endfunction : pin_pick

    // enables {spi, xtal, queue, synth, front-end, queue write}
    function automatic logic [5:0] power_of(input rsc_state_t st);
        unique case (st)
            ST_POR:                return 6'h00;
            ST_XTAL, ST_CAL:       return 6'h10;
            ST_SLEEP:              return 6'h20;
            ST_TO_STBY, ST_STBY:   return 6'h38;
            ST_TO_TUNE, ST_TUNE:   return 6'h3C;
            ST_TO_RX, ST_RX:       return 6'h3F;
            ST_EEPROM:             return 6'h30;
        endcase
    endfunction : power_of

    function automatic logic [2:0] code_of(input rsc_state_t st);
        unique case (st)
            ST_POR, ST_XTAL, ST_CAL: return `RSC_CODE_PUP;
            ST_SLEEP:                return `RSC_CODE_SLEEP;
            ST_TO_STBY, ST_STBY:     return `RSC_CODE_STBY;
            ST_TO_TUNE, ST_TUNE:     return `RSC_CODE_TUNE;
            ST_TO_RX, ST_RX:         return `RSC_CODE_RX;
            ST_EEPROM:               return `RSC_CODE_EEPROM;
        endcase
    endfunction : code_of

    logic       in_pup;
    logic       settled;
    logic       tick_edge;
    logic       wr_op;
    logic       soft_rst;
    logic [7:0] rd_mux;

    always_comb
    begin
        in_pup    = (cur.state == ST_POR) || (cur.state == ST_XTAL) ||
                    (cur.state == ST_CAL);
        settled   = (cur.state == cur.target);
        tick_edge = cur.tick_sync[1] & ~cur.tick_sync[2];
        wr_op     = reg_wr && (reg_addr == `RSC_OFS_OPERATION_CONTROL_REG) && !in_pup;
        soft_rst  = reg_wr && (reg_addr == `RSC_OFS_RESTART) &&
                    (reg_wdata == `RSC_SOFT_RESET_KEY);
    end

    always_comb
    begin
        nxt = cur;
        nxt.tick_sync = {cur.tick_sync[1:0], slow_oscillator};
        nxt.wake_evt  = 1'b0;
        nxt.irq_clr   = 8'h00; // see R22
        nxt.tmr       = (cur.tmr != '0) ? cur.tmr - rsc_tmr_t'(1) : '0;

        // register writes
        if (reg_wr)
        begin
            unique case (reg_addr)
                `RSC_OFS_PIN_SEL:     nxt.pin_sel     = reg_wdata;
                `RSC_OFS_IRQ_A_SEL:   nxt.irq_a_sel   = reg_wdata[3:0];
                `RSC_OFS_IRQ_B_SEL:   nxt.irq_b_sel   = reg_wdata[3:0]; // see R21
                `RSC_OFS_IRQ_EN:      nxt.irq_en      = reg_wdata;
                `RSC_OFS_IRQ_CLR:     nxt.irq_clr     = reg_wdata; // see R22
                `RSC_OFS_XTAL_STAB:   nxt.xtal_stab   = reg_wdata;
                `RSC_OFS_WAKE_CTL:    nxt.wake_en     = reg_wdata[0];
                `RSC_OFS_WAKE_PERIOD: nxt.wake_period = reg_wdata;
                default:              nxt.pin_sel     = cur.pin_sel;
            endcase
        end

        // wake timer runs on slow ticks only while resting in dormant
        if ((cur.state == ST_SLEEP) && settled && cur.wake_en)
        begin
            if (tick_edge)
            begin
                if (cur.wake_cnt + 8'h01 >= cur.wake_period)
                begin
                    nxt.wake_cnt = 8'h00;
                    nxt.wake_evt = 1'b1;
                    nxt.target   = ST_STBY; // see R10
                end
                else
                    nxt.wake_cnt = cur.wake_cnt + 8'h01;
            end
        end
        else
            nxt.wake_cnt = 8'h00;

        // the target is only a request, so writes mid-transition queue up
        if (wr_op)
        begin
            unique case (reg_wdata[4:0]) // see R4 see R23
                `RSC_CMD_SLEEP:  nxt.target = ST_SLEEP;
                `RSC_CMD_STBY:   nxt.target = ST_STBY;
                `RSC_CMD_TUNE:   nxt.target = ST_TUNE;
                `RSC_CMD_RX:     nxt.target = ST_RX;
                `RSC_CMD_EEPROM:
                    if ((cur.state == ST_SLEEP) && settled)
                        nxt.target = ST_EEPROM; // see R7
                default:         nxt.target = cur.target;
            endcase
        end

        // state sequencing; timed steps advance when the count runs out
        unique case (cur.state)
            ST_POR:
                if (cur.tmr == '0)
                begin
                    nxt.state = ST_XTAL;
                    nxt.tmr   = cyc_load(XTAL_CYC); // see R1
                end
            ST_XTAL:
                if (cur.tmr == '0)
                begin
                    nxt.state = ST_CAL;
                    nxt.tmr   = cyc_load(CAL_CYC); // see R2
                end
            ST_CAL:
                if (cur.tmr == '0)
                begin
                    nxt.state  = ST_SLEEP; // see R3
                    nxt.target = ST_SLEEP;
                end
            ST_SLEEP:
                if (cur.target == ST_EEPROM)
                    nxt.state = ST_EEPROM;
                else if (cur.target != ST_SLEEP)
                begin
                    nxt.state = ST_TO_STBY;
                    nxt.tmr   = cyc_load(int'(cur.xtal_stab) * XTAL_UNIT_CYC); // see R11
                end
            ST_TO_STBY:
                if (cur.tmr == '0)
                    nxt.state = ST_STBY;
            ST_STBY:
                if (cur.target == ST_SLEEP)
                    nxt.state = ST_SLEEP;
                else if ((cur.target == ST_TUNE) || (cur.target == ST_RX))
                begin
                    nxt.state = ST_TO_TUNE;
                    nxt.tmr   = cyc_load(TUNE_CYC); // see R13
                end
            ST_TO_TUNE:
                if (cur.tmr == '0)
                    nxt.state = ST_TUNE;
            ST_TUNE:
                if (cur.target == ST_RX)
                begin
                    nxt.state = ST_TO_RX;
                    nxt.tmr   = cyc_load(RX_CYC); // see R14
                end
                else if (cur.target != ST_TUNE)
                    nxt.state = cur.target;
            ST_TO_RX:
                if (cur.tmr == '0)
                    nxt.state = ST_RX;
            ST_RX:
                if (cur.target != ST_RX)
                    nxt.state = cur.target;
            ST_EEPROM:
                // crystal already runs here, so no settling step is needed
                if (cur.target == ST_SLEEP)
                    nxt.state = ST_SLEEP;
                else if (cur.target != ST_EEPROM)
                    nxt.state = ST_STBY;
        endcase

        // soft reset overrides everything; no hold, the crystal restarts
        if (soft_rst)
        begin
            nxt.state    = ST_XTAL; // see R8
            nxt.target   = ST_SLEEP;
            nxt.tmr      = cyc_load(XTAL_CYC);
            nxt.wake_cnt = 8'h00;
        end

        // enables and reset out follow the state being entered; pins route the current registered values
        nxt.reset_out_n = (nxt.state != ST_POR); // see R1
        nxt.power       = power_of(nxt.state); // see R5 see R9 see R12
        nxt.ref_clk     = nxt.power[4] ? ~cur.ref_clk : 1'b0;
        nxt.pins[0] = pin_pick(cur.pin_sel[1:0], cur.reset_out_n, irq_bus.irq_a,
                               irq_bus.irq_b, demod_data); // see R15
        nxt.pins[1] = pin_pick(cur.pin_sel[3:2], irq_bus.irq_a, irq_bus.irq_b,
                               bit_clock_in, 1'b0); // see R16
        nxt.pins[2] = pin_pick(cur.pin_sel[5:4], cur.ref_clk, irq_bus.irq_a,
                               irq_bus.irq_b, demod_data); // see R17
        nxt.pins[3] = pin_pick(cur.pin_sel[7:6], demod_data, irq_bus.irq_a,
                               irq_bus.irq_b, bit_clock_in); // see R18

        // read data stand only in the cycle after the strobe
        nxt.rd_data = reg_rd ? rd_mux : 8'h00;
    end

    always_comb
    begin
        unique case (reg_addr)
            `RSC_OFS_OPERATION_CONTROL_REG:     rd_mux = {5'h00, code_of(cur.target)};
            `RSC_OFS_STATUS:      rd_mux = {4'h0, !settled || in_pup,
                                            code_of(cur.state)};
            `RSC_OFS_PIN_SEL:     rd_mux = cur.pin_sel;
            `RSC_OFS_IRQ_A_SEL:   rd_mux = {4'h0, cur.irq_a_sel};
            `RSC_OFS_IRQ_B_SEL:   rd_mux = {4'h0, cur.irq_b_sel};
            `RSC_OFS_IRQ_EN:      rd_mux = cur.irq_en;
            `RSC_OFS_IRQ_CLR:     rd_mux = cur.irq_clr;
            `RSC_OFS_IRQ_LATCH:   rd_mux = irq_bus.latched;
            `RSC_OFS_IRQ_LIVE:    rd_mux = {2'h0, irq_bus.live_q};
            `RSC_OFS_XTAL_STAB:   rd_mux = cur.xtal_stab;
            `RSC_OFS_WAKE_CTL:    rd_mux = {7'h00, cur.wake_en};
            `RSC_OFS_WAKE_PERIOD: rd_mux = cur.wake_period;
            default:              rd_mux = 8'h00;
        endcase
    end

    // interrupt unit feeds; the wake event joins the host-cleared group
    assign irq_bus.evt    = src_events |
                            ({7'h00, cur.wake_evt} << `RSC_WAKE_IRQ_BIT); // see R19
    assign irq_bus.enable = cur.irq_en;
    assign irq_bus.clear  = cur.irq_clr;
    assign irq_bus.live   = queue_status; // see R20
    assign irq_bus.sel_a  = cur.irq_a_sel;
    assign irq_bus.sel_b  = cur.irq_b_sel;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur             <= '0;
            cur.state       <= ST_POR;
            cur.target      <= ST_SLEEP;
            cur.tmr         <= cyc_load(POR_CYC); // see R1
            cur.pin_sel     <= `RSC_RST_PIN_SEL;
            cur.irq_a_sel   <= `RSC_RST_IRQ_A_SEL;
            cur.irq_b_sel   <= `RSC_RST_IRQ_B_SEL;
            cur.xtal_stab   <= `RSC_RST_XTAL_STAB;
            cur.wake_period <= `RSC_RST_WAKE_PERIOD;
        end
        else
            cur <= nxt;
    end

    assign reg_rdata      = cur.rd_data;
    assign out_pin_a      = cur.pins[0];
    assign out_pin_b      = cur.pins[1];
    assign out_pin_c      = cur.pins[2];
    assign out_pin_d      = cur.pins[3];
    assign spi_on         = cur.power[5];
    assign xtal_on        = cur.power[4];
    assign queue_on       = cur.power[3];
    assign synth_on       = cur.power[2];
    assign frontend_on    = cur.power[1];
    assign queue_write_en = cur.power[0];
endmodule : rsc_state_ctl
`default_nettype wire

// [verif/rsc_state_ctl_checker.sv]
// port assertions for the state controller
`timescale 1ns/1ps
`default_nettype none
module rsc_state_ctl_checker #(
    parameter int unsigned POR_CYC  = 12500,
    parameter int unsigned XTAL_CYC = 62500,
    parameter int unsigned CAL_CYC  = 162500
)
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       out_pin_a,
    input wire logic       spi_on,
    input wire logic       xtal_on,
    input wire logic       queue_on,
    input wire logic       synth_on,
    input wire logic       frontend_on,
    input wire logic       queue_write_en
);
    int unsigned cyc_ff;
    // saturates: no wrap into power-up window
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            cyc_ff <= 0;
        else
            cyc_ff <= cyc_ff + 32'(cyc_ff < 1000000);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_read_slot_only: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data out of slot");
    a_por_quiet: assert property (cyc_ff < POR_CYC |-> !xtal_on && !spi_on && !out_pin_a)
        else $error("active in power-on hold");
    a_cal_no_port: assert property (cyc_ff < POR_CYC + XTAL_CYC + CAL_CYC |-> !spi_on)
        else $error("port on in calibration");
    a_auto_dormant: assert property (cyc_ff == POR_CYC + XTAL_CYC + CAL_CYC + 5
        |-> spi_on && !xtal_on) else $error("no dormant after power-up");
    a_receive_all_on: assert property (frontend_on
        |-> spi_on && xtal_on && queue_on && synth_on) else $error("receive lacks blocks");
    a_lock_chain: assert property (synth_on |-> queue_on && xtal_on && spi_on)
        else $error("lock lacks standby blocks");
    a_dormant_no_queue: assert property (spi_on && !xtal_on
        |-> !queue_on && !queue_write_en) else $error("queue open in dormant");
    a_nv_entry: assert property (spi_on && xtal_on && !queue_on
        |-> $past(spi_on && xtal_on && !queue_on) || $past(spi_on && !xtal_on))
        else $error("nv access from wrong state");
    a_lock_delay: assert property ($rose(synth_on) |=> (!frontend_on) [*8])
        else $error("receive too soon");
    a_queue_write_rx: assert property (queue_write_en |-> frontend_on)
        else $error("queue write outside receive");
endmodule : rsc_state_ctl_checker
bind rsc_state_ctl rsc_state_ctl_checker #(.POR_CYC(POR_CYC), .XTAL_CYC(XTAL_CYC),
    .CAL_CYC(CAL_CYC)) chk_u (.clk_sys, .rst_n, .reg_rd, .reg_rdata, .out_pin_a, .spi_on,
    .xtal_on, .queue_on, .synth_on, .frontend_on, .queue_write_en);
`default_nettype wire

// [verif/rsc_mcu_model.sv]
// host microcontroller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module rsc_mcu_model (
    input  wire logic       clk_sys,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask : rd
    // polls busy: no action before all steps elapse
    task automatic settle(output logic [7:0] s);
        s = 8'h08;
        for (int i = 0; i < 600 && s[3] !== 1'h0; i++)
            rd(8'h02, s);
    endtask : settle
    task automatic cmd(input logic [7:0] c, output logic [7:0] s);
        wr(8'h00, c);
        settle(s);
    endtask : cmd
endmodule : rsc_mcu_model
`default_nettype wire

// [verif/rsc_state_ctl_tb_top.sv]
// testbench for the state controller
`timescale 1ns/1ps
`default_nettype none
module rsc_state_ctl_tb_top;
    logic       clk_sys = 1'h0;
    logic       rst_n = 1'h0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, s;
    logic       reg_wr, reg_rd, out_pin_a, out_pin_b, out_pin_c, out_pin_d;
    logic       spi_on, xtal_on, queue_on, synth_on, frontend_on, queue_write_en;
    logic [7:0] src_events = 8'h00;
    logic [5:0] queue_status = 6'h00;
    logic       demod_data = 1'h0, bit_clock_in = 1'h0, slow_oscillator = 1'h0;
    logic [7:0] ra [4] = '{8'h0A, 8'h0C, 8'h03, 8'hFF};
    logic [7:0] re [4] = '{8'h32, 8'h0A, 8'h00, 8'h00};
    logic [7:0] pexp [4] = '{8'h09, 8'h04, 8'h0F, 8'h0B};
    int         num_errors = 0, num_checks = 0, cyc = 0, n;
    always #20 clk_sys = ~clk_sys;
    rsc_state_ctl #(.POR_CYC(20), .XTAL_CYC(30), .CAL_CYC(40), .TUNE_CYC(25)) dut_u (
        .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .src_events,
        .queue_status, .demod_data, .bit_clock_in, .slow_oscillator, .out_pin_a, .out_pin_b,
        .out_pin_c, .out_pin_d, .spi_on, .xtal_on, .queue_on, .synth_on, .frontend_on,
        .queue_write_en);
    rsc_mcu_model mcu_u (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask : tick
    task automatic ev(input int b);
        src_events[b] <= 1'h1;
        tick(1);
        src_events[b] <= 1'h0;
    endtask : ev
    function automatic logic [7:0] pw();
        return {2'h0, spi_on, xtal_on, queue_on, synth_on, frontend_on, queue_write_en};
    endfunction : pw
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            test_done();
        end
    end
    initial
    begin
        tick(8);
        rst_n <= 1'h1;
        tick(5);
        chk("pin_a_por", 8'(out_pin_a), 8'h00);
        tick(100);
        mcu_u.settle(s);
        chk("dormant", s, 8'h01);
        chk("pw_dormant", pw(), 8'h20);
        for (int i = 0; i < 4; i++)
        begin
            mcu_u.rd(ra[i], s);
            chk("reg_rst", s, re[i]);
        end
        mcu_u.wr(8'h0A, 8'h01);
        mcu_u.wr(8'h00, 8'h04);
        mcu_u.cmd(8'h02, s);
        chk("last_cmd", s, 8'h02);
        chk("pw_stby", pw(), 8'h38);
        mcu_u.cmd(8'h01, s);
        mcu_u.wr(8'h00, 8'h08);
        n = cyc;
        mcu_u.rd(8'h02, s);
        chk("moving", s, 8'h0A);
        mcu_u.settle(s);
        chk("rx", s, 8'h04);
        chk("rx_time", 8'(cyc - n >= 775), 8'h01);
        chk("pw_rx", pw(), 8'h3F);
        mcu_u.cmd(8'h01, s);
        mcu_u.cmd(8'h10, s);
        chk("nv", s, 8'h05);
        chk("pw_nv", pw(), 8'h30);
        mcu_u.cmd(8'h02, s);
        mcu_u.cmd(8'h10, s);
        chk("nv_refused", s, 8'h02);
        mcu_u.wr(8'h06, 8'h04);
        mcu_u.wr(8'h04, 8'h02);
        mcu_u.wr(8'h03, 8'h01);
        ev(2);
        tick(4);
        chk("pin_a_irq", 8'(out_pin_a), 8'h01);
        mcu_u.rd(8'h08, s);
        chk("latched", s, 8'h04);
        mcu_u.wr(8'h07, 8'h04);
        mcu_u.rd(8'h07, s);
        chk("clear_self", s, 8'h00);
        mcu_u.rd(8'h08, s);
        chk("latched_clr", s, 8'h00);
        mcu_u.wr(8'h06, 8'h00);
        ev(2);
        mcu_u.rd(8'h08, s);
        chk("latched_off", s, 8'h00);
        mcu_u.wr(8'h05, 8'h08);
        queue_status <= 6'h01;
        demod_data <= 1'h1;
        bit_clock_in <= 1'h1;
        // pin c masked: ref clock toggles
        for (int k = 0; k < 4; k++)
        begin
            mcu_u.wr(8'h03, 8'(k * 8'h55));
            tick(4);
            chk("pins", {4'h0, out_pin_a, out_pin_b, out_pin_c & (k != 0), out_pin_d}, pexp[k]);
        end
        mcu_u.wr(8'h03, 8'h02);
        queue_status <= 6'h00;
        tick(4);
        chk("live_clear", 8'(out_pin_a), 8'h00);
        mcu_u.wr(8'h03, 8'h00);
        mcu_u.cmd(8'h01, s);
        mcu_u.wr(8'h0C, 8'h02);
        mcu_u.wr(8'h0B, 8'h01);
        repeat (3)
        begin
            slow_oscillator <= 1'h1;
            tick(4);
            slow_oscillator <= 1'h0;
            tick(4);
        end
        mcu_u.settle(s);
        chk("wake", s, 8'h02);
        mcu_u.wr(8'h01, 8'hFF);
        tick(2);
        chk("pw_reset", pw(), 8'h10);
        tick(90);
        mcu_u.settle(s);
        chk("after_reset", s, 8'h01);
        test_done();
    end
endmodule : rsc_state_ctl_tb_top
`default_nettype wire
